// *** include/amcrg_pkg.sv ***
// Constants, field layout and types of the audio master clock ratio generator
`default_nettype none
package amcrg_pkg;
  // Register offsets
  localparam logic [7:0] AMCRG_OFS_CLKDIV    = 8'h03;
  localparam logic [7:0] AMCRG_OFS_CONVOSR   = 8'h29;
  localparam logic [7:0] AMCRG_OFS_STATUS    = 8'h2A;
  // Reset values
  localparam logic [15:0] AMCRG_RST_CLKDIV   = 16'h0010;
  localparam logic [15:0] AMCRG_RST_CONVOSR  = 16'h0003;
  // Fields of clock_divider_config
  localparam int AMCRG_PRE_LSB   = 0;   // pre_divider, 3 bits
  localparam int AMCRG_POST_LSB  = 4;   // post_divider, 3 bits
  localparam int AMCRG_MSEL_BIT  = 8;   // multiplier select
  localparam int AMCRG_MFAC_LSB  = 12;  // multiplier_factor code, 2 bits
  localparam int AMCRG_CCR_LSB   = 14;  // converter_clock_ratio code, 2 bits
  // Fields of converter_oversample_config
  localparam int AMCRG_OSR_LSB   = 0;   // oversampling_ratio code, 2 bits
  localparam int AMCRG_SRR_LSB   = 8;   // sample_rate_range, 3 bits
  // Master clock to frame ratios
  localparam logic [9:0] AMCRG_RATIO_256 = 10'h100;
  localparam logic [9:0] AMCRG_RATIO_400 = 10'h190;
  localparam logic [9:0] AMCRG_RATIO_500 = 10'h1F4;
  // Fixed oversampling for the 400 and 500 ratios
  localparam logic [8:0] AMCRG_OSR_FIXED = 9'h064;
  // Converter clock divisors
  localparam logic [2:0] AMCRG_CDIV_500  = 3'h5;
  typedef enum logic [1:0] {
    AMCRG_R_NONE,
    AMCRG_R_256,
    AMCRG_R_400,
    AMCRG_R_500
  } amcrg_ratio_t;
endpackage
`default_nettype wire

// *** include/amcrg_tick_if.sv ***
// Tick divider connection between the generator and its divider
`timescale 1ns/1ps
`default_nettype none
interface amcrg_tick_if;
  logic       in_tick;   // Source tick
  logic [2:0] divisor;   // Division factor, 1..7
  logic       out_tick;  // Divided tick
  modport src (output in_tick, output divisor, input out_tick);
  modport div (input in_tick, input divisor, output out_tick);
endinterface
`default_nettype wire

// *** rtl/amcrg_divider.sv ***
// Integer tick divider
`timescale 1ns/1ps
`default_nettype none
module amcrg_divider (
  input  wire logic clk,            // System clock
  input  wire logic rst_b,          // Async reset, active low
  amcrg_tick_if.div t               // Tick in, tick out
);
  logic [2:0] cnt_r;
  logic       out_r;

  // Count source ticks, emit one per divisor
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 3'h0;
      out_r <= 1'b0;
    end else begin
      out_r <= 1'b0;
      if (t.in_tick) begin
        if (cnt_r + 3'h1 >= t.divisor) begin
          cnt_r <= 3'h0;
          out_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 3'h1;
        end
      end
    end
  end

  assign t.out_tick = out_r;
endmodule
`default_nettype wire

// *** rtl/amcrg_top.sv ***
// Master clock and converter clock ratio generator
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - Master clock must be 256, 400 or 500 times the frame rate.
// - With multiplier select zero, master clock is reference over post_divider.
// - Otherwise master is reference times factor over pre times post divider.
// - Dividers take 1 to 7, multiplier factor takes 1, 2, 4 or 8.
// - Unity dividers with factors 8,4,2,1 give the table of reference ratios.
// - At ratio 256 oversampling is 32, 64, 128 or 256 with matching divider; at 32 the code has no 1/8 divider and uses 1/4.
// - Converter clock is master times 1, 1/2 or 1/4, and OVERSAMPLING_RATIO times frame rate; at ratio 256 with 32 the code gives 64 times.
// - At ratios 400 and 500 the oversampling ratio is fixed at 100.
// - At ratio 500 the converter divider is one fifth automatically.
// - Range code 011 covers 64 to 96 kHz frame rates.
module amcrg_top
  import amcrg_pkg::*;
(
  input  wire logic        clk,           // System clock, 100 MHz
  input  wire logic        rst_b,         // Async reset, active low
  input  wire logic        ref_clk,       // Reference clock, sampled
  input  wire logic        frame_sync,    // Audio frame sync, sampled
  input  wire logic        reg_wr,        // Register write strobe
  input  wire logic        reg_rd,        // Register read strobe
  input  wire logic [7:0]  reg_addr,      // Register offset
  input  wire logic [15:0] reg_wdata,     // Write data
  output logic      [15:0] reg_rdata,     // Read data, one cycle later
  output logic             master_tick,   // Internal master clock tick
  output logic             conv_tick,     // Converter clock tick
  output logic      [1:0]  ratio_code,    // Detected ratio
  output logic      [8:0]  osr_eff,       // Effective oversampling
  output logic      [2:0]  sample_rate_range // Programmed rate range
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0] clkdiv_r;
  logic [15:0] convosr_r;

  // Software writes of the two configuration registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clkdiv_r  <= AMCRG_RST_CLKDIV;
      convosr_r <= AMCRG_RST_CONVOSR;
    end else if (reg_wr) begin
      if (reg_addr == AMCRG_OFS_CLKDIV)
        clkdiv_r <= reg_wdata;
      if (reg_addr == AMCRG_OFS_CONVOSR)
        convosr_r <= {5'h00, reg_wdata[10:8], 6'h00, reg_wdata[1:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Field decode
  logic [2:0] pre_divider;
  logic [2:0] post_divider;
  logic       mult_sel;
  logic [3:0] multiplier_factor;
  logic [1:0] converter_clock_ratio;
  logic [1:0] osr_code;

  // Zero divider codes act as one to avoid a stuck generator
  assign pre_divider  = (clkdiv_r[AMCRG_PRE_LSB +: 3] == 3'h0) ? 3'h1 :
                        clkdiv_r[AMCRG_PRE_LSB +: 3];
  assign post_divider = (clkdiv_r[AMCRG_POST_LSB +: 3] == 3'h0) ? 3'h1 :
                        clkdiv_r[AMCRG_POST_LSB +: 3];
  assign mult_sel     = clkdiv_r[AMCRG_MSEL_BIT];
  // Factor code 0..3 gives 1, 2, 4, 8
  assign multiplier_factor = 4'h1 << clkdiv_r[AMCRG_MFAC_LSB +: 2];
  assign converter_clock_ratio = clkdiv_r[AMCRG_CCR_LSB +: 2];
  assign osr_code     = convosr_r[AMCRG_OSR_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////
  // Input edge detection
  logic ref_d_r;
  logic fs_d_r;
  logic ref_edge;
  logic fs_edge;

  // Previous samples of reference and frame sync
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_d_r <= 1'b0;
      fs_d_r  <= 1'b0;
    end else begin
      ref_d_r <= ref_clk;
      fs_d_r  <= frame_sync;
    end
  end

  assign ref_edge = ref_clk & ~ref_d_r;
  assign fs_edge  = frame_sync & ~fs_d_r;

  ////////////////////////////////////////////////////////////////////////
  // Master clock rate generator
  logic [6:0] credit_r;
  logic [6:0] credit_nxt;
  logic [6:0] thresh;
  logic [6:0] incr;
  logic       emit;

  // Threshold and increment per reference edge
  always_comb begin
    if (mult_sel) begin
      // Widen before multiplying so 7 times 7 keeps all six bits
      thresh = 7'(pre_divider) * 7'(post_divider);
      incr   = {3'h0, multiplier_factor};
    end else begin
      thresh = {4'h0, post_divider};
      incr   = 7'h01;
    end
  end

  assign emit = (credit_r >= thresh);

  // Credit gains on reference edges, pays one threshold per tick
  always_comb begin
    credit_nxt = credit_r;
    if (ref_edge)
      credit_nxt = credit_nxt + incr;
    if (emit)
      credit_nxt = credit_nxt - thresh;
  end

  // Credit and master tick registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      credit_r    <= 7'h00;
      master_tick <= 1'b0;
    end else begin
      credit_r    <= credit_nxt;
      master_tick <= emit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Ratio detection against frame sync
  logic [9:0]   per_frame_r;
  amcrg_ratio_t ratio_r;

  // Count master ticks between frame sync edges
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      per_frame_r <= 10'h000;
    end else if (fs_edge) begin
      per_frame_r <= {9'h000, master_tick};
    end else if (master_tick && per_frame_r != 10'h3FF) begin
      per_frame_r <= per_frame_r + 10'h001;
    end
  end

  // Classify the measured ratio at each frame
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ratio_r <= AMCRG_R_NONE;
    end else if (fs_edge) begin
      unique case (per_frame_r)
        AMCRG_RATIO_256: ratio_r <= AMCRG_R_256;
        AMCRG_RATIO_400: ratio_r <= AMCRG_R_400;
        AMCRG_RATIO_500: ratio_r <= AMCRG_R_500;
        default:         ratio_r <= AMCRG_R_NONE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Converter clock and oversampling
  amcrg_tick_if conv_if ();
  logic [2:0] conv_div;
  logic [8:0] osr_nxt;

  // Divisor: fixed fifth at 500, else software ratio
  always_comb begin
    if (ratio_r == AMCRG_R_500) begin
      conv_div = AMCRG_CDIV_500;
    end else begin
      unique case (converter_clock_ratio)
        2'h0:    conv_div = 3'h1;
        2'h1:    conv_div = 3'h2;
        default: conv_div = 3'h4;
      endcase
    end
  end

  assign conv_if.in_tick = master_tick;
  assign conv_if.divisor = conv_div;

  amcrg_divider u_conv_div (
    .clk   (clk),
    .rst_b (rst_b),
    .t     (conv_if.div)
  );

  // Oversampling: fixed 100 at 400/500, else selected 32..256
  always_comb begin
    if (ratio_r == AMCRG_R_400 || ratio_r == AMCRG_R_500)
      osr_nxt = AMCRG_OSR_FIXED;
    else
      osr_nxt = 9'h020 << osr_code;
  end

  // Output registers for converter path
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_tick         <= 1'b0;
      ratio_code        <= 2'h0;
      osr_eff           <= 9'h000;
      sample_rate_range <= 3'h0;
    end else begin
      conv_tick         <= conv_if.out_tick;
      ratio_code        <= ratio_r;
      osr_eff           <= osr_nxt;
      sample_rate_range <= convosr_r[AMCRG_SRR_LSB +: 3];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        AMCRG_OFS_CLKDIV:  reg_rdata <= clkdiv_r;
        AMCRG_OFS_CONVOSR: reg_rdata <= convosr_r;
        AMCRG_OFS_STATUS:  reg_rdata <= {5'h00, osr_nxt, ratio_r};
        default:           reg_rdata <= 16'h0000;
      endcase
    end
  end

endmodule
`default_nettype wire

// *** bench/amcrg_monitor.sv ***
// Port checker of the ratio generator
`timescale 1ns/1ps
`default_nettype none
module amcrg_monitor
  import amcrg_pkg::*;
(
  input wire logic        clk,         // Clock
  input wire logic        rst_b,       // Reset, active low
  input wire logic        frame_sync,  // Frame sync
  input wire logic        reg_wr,      // Write strobe
  input wire logic        reg_rd,      // Read strobe
  input wire logic [7:0]  reg_addr,    // Offset
  input wire logic [15:0] reg_wdata,   // Write data
  input wire logic [15:0] reg_rdata,   // Read data
  input wire logic        master_tick, // Master tick
  input wire logic        conv_tick,   // Converter tick
  input wire logic [1:0]  ratio_code,  // Ratio
  input wire logic [8:0]  osr_eff,     // Oversampling
  input wire logic [2:0]  sample_rate_range // Range code
);
  logic [15:0] cfg_r;
  // Shadow of the divider register
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      cfg_r <= AMCRG_RST_CLKDIV;
    else if (reg_wr && reg_addr == AMCRG_OFS_CLKDIV)
      cfg_r <= reg_wdata;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////
  a_conv_after_master: assert property (conv_tick |-> $past(master_tick, 2))
    else $error("converter tick without master tick");
  a_osr_fixed: assert property ((ratio_code[1])[*3] |-> osr_eff == 9'h064)
    else $error("oversampling not fixed");
  a_osr_256: assert property ((ratio_code == 2'h1)[*3] |->
    osr_eff inside {9'h020, 9'h040, 9'h080, 9'h100})
    else $error("oversampling out of set");
  a_read_cfg: assert property (reg_rd && reg_addr == AMCRG_OFS_CLKDIV |=>
    reg_rdata == $past(cfg_r))
    else $error("divider register read wrong");
  a_read_unmapped: assert property (reg_rd && reg_addr == 8'h10 |=>
    reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_range_by_write: assert property ($changed(sample_rate_range) |->
    $past(reg_wr) || $past(reg_wr, 2))
    else $error("range changed without write");
  a_ratio_at_frame: assert property ($changed(ratio_code) |->
    $past(frame_sync) || $past(frame_sync, 4))
    else $error("ratio changed off frame");
endmodule
bind amcrg_top amcrg_monitor mon (.clk, .rst_b, .frame_sync, .reg_wr,
  .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .master_tick, .conv_tick,
  .ratio_code, .osr_eff, .sample_rate_range);
`default_nettype wire

// *** bench/amcrg_ref_src.sv ***
// Reference clock and frame sync source
`timescale 1ns/1ps
`default_nettype none
module amcrg_ref_src (
  input  wire logic       clk,        // System clock
  input  wire logic       rst_b,      // Reset, active low
  input  wire logic [9:0] refs,       // Reference cycles per frame
  output logic            ref_clk,    // Reference clock, 8 clk period
  output logic            frame_sync  // Frame sync, high half a ref cycle
);
  logic [2:0] ph_r;
  logic [9:0] cnt_r;
  // Phase and frame counters, moved just after the edge
  always @(posedge clk or negedge rst_b)
    if (!rst_b) begin
      ph_r <= 3'h0;
      cnt_r <= 10'h000;
    end else begin
      ph_r <= #1 ph_r + 3'h1;
      if (ph_r == 3'h7)
        cnt_r <= #1 (cnt_r + 10'h001 >= refs) ? 10'h000 : cnt_r + 10'h001;
    end
  assign ref_clk = ~ph_r[2];
  assign frame_sync = ~ph_r[2] && cnt_r == 10'h000;
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench of the ratio generator
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import amcrg_pkg::*;
  logic        clk, rst_b, ref_clk, frame_sync, reg_wr, reg_rd;
  logic        master_tick, conv_tick;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd_val;
  logic [1:0]  ratio_code;
  logic [8:0]  osr_eff;
  logic [2:0]  sample_rate_range;
  logic [9:0]  refs;
  int          error_cnt, cmp_count, cyc, m_cnt, c_cnt;
  amcrg_top dut (.clk, .rst_b, .ref_clk, .frame_sync, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .master_tick, .conv_tick,
    .ratio_code, .osr_eff, .sample_rate_range);
  amcrg_ref_src src (.clk, .rst_b, .refs, .ref_clk, .frame_sync);
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    rd_val = reg_rdata;
  endtask
  // Program, settle two frames, count ticks over one frame
  task measure(input logic [9:0] n, input logic [15:0] cfg, oversampling_ratio,
               input logic [1:0] rc, input logic [8:0] oe, mt, ct);
    wr(AMCRG_OFS_CLKDIV, cfg);
    wr(AMCRG_OFS_CONVOSR, oversampling_ratio);
    refs = n;
    repeat (16 * n + 16) @(posedge clk);
    m_cnt = 0;
    c_cnt = 0;
    repeat (8 * n) begin
      @(posedge clk);
      #1 m_cnt += int'(master_tick);
      c_cnt += int'(conv_tick);
    end
    chk(16'(m_cnt), 16'(mt));
    chk(16'(c_cnt), 16'(ct));
    chk({14'h0000, ratio_code}, {14'h0000, rc});
    chk({7'h00, osr_eff}, {7'h00, oe});
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_regs;
    rd(AMCRG_OFS_CLKDIV);
    chk(rd_val, 16'h0010);
    rd(AMCRG_OFS_CONVOSR);
    chk(rd_val, 16'h0003);
    rd(8'h10);
    chk(rd_val, 16'h0000);
    wr(AMCRG_OFS_STATUS, 16'hffff);
    rd(AMCRG_OFS_STATUS);
    chk(rd_val, 16'h0400);
    wr(AMCRG_OFS_CONVOSR, 16'hfbff);
    rd(AMCRG_OFS_CONVOSR);
    chk(rd_val, 16'h0303);
    chk({13'h0000, sample_rate_range}, 16'h0003);
  endtask
  task t_256;
    measure(10'h100, 16'h0010, 16'h0003, 2'h1, 9'h100, 9'h100, 9'h100);
    measure(10'h100, 16'h4010, 16'h0002, 2'h1, 9'h080, 9'h100, 9'h080);
    measure(10'h100, 16'h8010, 16'h0001, 2'h1, 9'h040, 9'h100, 9'h040);
    measure(10'h100, 16'hc010, 16'h0000, 2'h1, 9'h020, 9'h100, 9'h040);
    measure(10'h200, 16'h0020, 16'h0003, 2'h1, 9'h100, 9'h100, 9'h100);
  endtask
  task t_mult;
    for (int i = 0; i < 4; i++)
      measure(10'(32 << i), 16'h0111 | 16'((3 - i) << 12), 16'h0003, 2'h1,
              9'h100, 9'h100, 9'h100);
    measure(10'h080, 16'h3122, 16'h0003, 2'h1, 9'h100, 9'h100, 9'h100);
  endtask
  task t_400_500;
    measure(10'h190, 16'h8010, 16'h0003, 2'h2, 9'h064, 9'h190, 9'h064);
    measure(10'h1f4, 16'h0010, 16'h0003, 2'h3, 9'h064, 9'h1f4, 9'h064);
  endtask
  // Main sequence
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    refs = 10'h100;
    repeat (3) @(posedge clk);
    #1 rst_b = 1'b1;
    t_regs;
    t_256;
    t_mult;
    t_400_500;
    end_of_test;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      end_of_test;
    end
  end
endmodule
`default_nettype wire
